// ===== inc/spsf_map.vh
// spsf_map.vh: register offsets, field positions, reset values for the serial status flag bank
// assumes: included by the design files of the spsf block; definitions only
`ifndef SPSF_MAP_VH
`define SPSF_MAP_VH

// ----------------------------------------------------------------------
// word offsets (byte addresses, one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define SPSF_OFS_P01 8'h00
`define SPSF_OFS_MODE 8'h04
`define SPSF_OFS_LINK 8'h08
`define SPSF_OFS_UNIT 8'h0C
`define SPSF_OFS_P01_ALT 8'h10
`define SPSF_OFS_MODE_ALT 8'h14
`define SPSF_OFS_LINK_ALT 8'h18
`define SPSF_OFS_UNIT_ALT 8'h1C
`define SPSF_OFS_IRQ_STAT 8'h20
`define SPSF_OFS_IRQ_EN 8'h24
`define SPSF_OFS_IRQ_CLR 8'h28
`define SPSF_OFS_ERR_P1 8'h2C
`define SPSF_OFS_ERR_P2 8'h30

// ----------------------------------------------------------------------
// field positions, port0/port1 word
// ----------------------------------------------------------------------
`define SPSF_B_P1_MODE 2
`define SPSF_B_P1_ERR 7
`define SPSF_B_P1_RXD 8
`define SPSF_B_P1_TXD 9
`define SPSF_B_P0_RXD 14
`define SPSF_B_P0_TXD 15

// ----------------------------------------------------------------------
// field positions, mode and remote operation word
// ----------------------------------------------------------------------
`define SPSF_B_P0_MODE 0
`define SPSF_B_P1_LINK 1
`define SPSF_B_P2_MODE 2
`define SPSF_B_P1_AVAIL 4
`define SPSF_B_P1_END 5
`define SPSF_B_P2_ERR 7
`define SPSF_B_P2_RXD 8
`define SPSF_B_P2_TXD 9
`define SPSF_B_P2_AVAIL 10
`define SPSF_B_P2_END 11

// ----------------------------------------------------------------------
// link word, unit word, interrupt event bits
// ----------------------------------------------------------------------
`define SPSF_B_LINK_ERR 0
`define SPSF_UNITS 4
`define SPSF_EVENTS 8
`define SPSF_EV_P0_RXD 0
`define SPSF_EV_P0_TXD 1
`define SPSF_EV_P1_ERR 2
`define SPSF_EV_P2_ERR 3
`define SPSF_EV_P2_RXD 4
`define SPSF_EV_P2_TXD 5
`define SPSF_EV_REM_END 6
`define SPSF_EV_LINK_ERR 7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPSF_RST_WORD 16'h0000
`define SPSF_RST_ERRCODE 16'h0000
`define SPSF_RST_IRQ 8'h00

`endif

// ===== src/spsf_sync.v
// spsf_sync.v: two flip-flop synchroniser for a bundle of pin levels
// assumes: inputs arrive from outside the clock domain; ce freezes state
`timescale 1ns/1ns
module spsf_sync #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta;

  // first stage is read by the second stage only
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ===== src/spsf_top.v
// spsf_top.v: status flag bank for three serial ports and the inter-controller link
// assumes: port and link engines drive level and pulse pins asynchronously;
// software reads over classic wishbone, 32-bit data, one cycle ack
//
// Functional notes
// - port0 reception-done set on terminating code
// - port0 transmit-done set on end, cleared on request
// - flags update at once, no scan latching
// - port, mode, link and unit word bits mirrored at alternate address
// - port0/port2 mode flags follow general-purpose mode
// - port1 link flag while assigned to link
// - port1 remote availability: 0 busy, 1 ready
// - port1 remote end: 1 error, code stored
// - port2 remote availability, end flag, code stored
// - port2 error set on error, cleared by transmit
// - port2 receive and transmit done flags
// - link error on link fault or bad settings
// - unit assurance bit high while unit normal
// - port1 error set on error, cleared by transmit
`timescale 1ns/1ns
`include "spsf_map.vh"
module spsf_top (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire CE_I,
  // wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  output reg INT_O,
  // port engines, levels
  input wire P0_GP_MODE_I,
  input wire P2_GP_MODE_I,
  input wire P1_LINK_MODE_I,
  input wire P1_REM_BUSY_I,
  input wire P2_REM_BUSY_I,
  input wire [`SPSF_UNITS-1:0] UNIT_OK_I,
  input wire LINK_CFG_BAD_I,
  // port engines, pulses (one cycle or longer, edge taken)
  input wire P0_RX_END_I,
  input wire P0_TX_DONE_I,
  input wire P0_TX_REQ_I,
  input wire P1_TX_ERR_I,
  input wire P1_TX_REQ_I,
  input wire P2_RX_END_I,
  input wire P2_TX_DONE_I,
  input wire P2_TX_REQ_I,
  input wire P2_TX_ERR_I,
  input wire LINK_TX_ERR_I,
  input wire P1_REM_DONE_I,
  input wire P1_REM_FAIL_I,
  input wire [15:0] P1_REM_CODE_I,
  input wire P2_REM_DONE_I,
  input wire P2_REM_FAIL_I,
  input wire [15:0] P2_REM_CODE_I
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam NS = 24;
  wire [NS-1:0] pin_raw;
  wire [NS-1:0] pin_s;
  assign pin_raw = {P0_GP_MODE_I, P2_GP_MODE_I, P1_LINK_MODE_I, P1_REM_BUSY_I,
    P2_REM_BUSY_I, UNIT_OK_I, LINK_CFG_BAD_I, P0_RX_END_I, P0_TX_DONE_I,
    P0_TX_REQ_I, P1_TX_ERR_I, P1_TX_REQ_I, P2_RX_END_I, P2_TX_DONE_I,
    P2_TX_REQ_I, P2_TX_ERR_I, LINK_TX_ERR_I, P1_REM_DONE_I, P1_REM_FAIL_I,
    P2_REM_DONE_I, P2_REM_FAIL_I};

  spsf_sync #(
    .W(NS)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  wire p0_mode = pin_s[23];
  wire p2_mode = pin_s[22];
  wire p1_link = pin_s[21];
  wire p1_busy = pin_s[20];
  wire p2_busy = pin_s[19];
  wire [`SPSF_UNITS-1:0] unit_ok = pin_s[18:15];
  wire link_cfg_bad = pin_s[14];
  wire [13:0] ev_lvl = pin_s[13:0];
  reg [13:0] ev_prev;
  wire [13:0] ev = ev_lvl & ~ev_prev;

  wire e_p0_rx = ev[13];
  wire e_p0_txd = ev[12];
  wire e_p0_req = ev[11];
  wire e_p1_err = ev[10];
  wire e_p1_req = ev[9];
  wire e_p2_rx = ev[8];
  wire e_p2_txd = ev[7];
  wire e_p2_req = ev[6];
  wire e_p2_err = ev[5];
  wire e_link_err = ev[4];
  wire e_p1_done = ev[3];
  wire e_p1_fail = ev[2];
  wire e_p2_done = ev[1];
  wire e_p2_fail = ev[0];

  // codes are held stable by the engine around its fail pulse, so two stages suffice
  reg [15:0] p1_code_m;
  reg [15:0] p1_code_s;
  reg [15:0] p2_code_m;
  reg [15:0] p2_code_s;

  // ----------------------------------------------------------------------
  // flag state
  // ----------------------------------------------------------------------
  reg p0_rxd;
  reg p0_txd;
  reg p1_err;
  reg p2_err;
  reg p2_rxd;
  reg p2_txd;
  reg p1_end;
  reg p2_end;
  reg link_err;
  reg [15:0] p1_errcode;
  reg [15:0] p2_errcode;
  reg [`SPSF_EVENTS-1:0] irq_stat;
  reg [`SPSF_EVENTS-1:0] irq_en;

  // set beats clear so an event in the clear cycle is kept
  function set_clr;
    input cur;
    input set;
    input clr;
    begin
      set_clr = set | (cur & ~clr);
    end
  endfunction

  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ev_prev <= 14'h0000;
      p1_code_m <= `SPSF_RST_ERRCODE;
      p1_code_s <= `SPSF_RST_ERRCODE;
      p2_code_m <= `SPSF_RST_ERRCODE;
      p2_code_s <= `SPSF_RST_ERRCODE;
      p0_rxd <= 1'b0;
      p0_txd <= 1'b0;
      p1_err <= 1'b0;
      p2_err <= 1'b0;
      p2_rxd <= 1'b0;
      p2_txd <= 1'b0;
      p1_end <= 1'b0;
      p2_end <= 1'b0;
      link_err <= 1'b0;
      p1_errcode <= `SPSF_RST_ERRCODE;
      p2_errcode <= `SPSF_RST_ERRCODE;
    end else if (CE_I) begin
      ev_prev <= ev_lvl;
      p1_code_m <= P1_REM_CODE_I;
      p1_code_s <= p1_code_m;
      p2_code_m <= P2_REM_CODE_I;
      p2_code_s <= p2_code_m;
      // flags move the cycle after the event, never held for a scan
      // reception-done stays set; the next arrival keeps it set
      p0_rxd <= p0_rxd | (p0_mode & e_p0_rx);
      p0_txd <= set_clr(p0_txd, p0_mode & e_p0_txd, e_p0_req);
      p1_err <= set_clr(p1_err, e_p1_err, e_p1_req);
      p2_err <= set_clr(p2_err, e_p2_err, e_p2_req);
      p2_rxd <= p2_rxd | (p2_mode & e_p2_rx);
      p2_txd <= set_clr(p2_txd, p2_mode & e_p2_txd, e_p2_req);
      link_err <= link_err | e_link_err | link_cfg_bad;
      if (e_p1_fail) begin
        p1_end <= 1'b1;
        p1_errcode <= p1_code_s;
      end else if (e_p1_done) begin
        p1_end <= 1'b0;
      end
      if (e_p2_fail) begin
        p2_end <= 1'b1;
        p2_errcode <= p2_code_s;
      end else if (e_p2_done) begin
        p2_end <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------------
  reg [15:0] w_p01;
  reg [15:0] w_mode;
  wire [15:0] w_link = {15'h0000, link_err};
  wire [15:0] w_unit = {12'h000, unit_ok};

  always @* begin
    w_p01 = `SPSF_RST_WORD;
    w_p01[`SPSF_B_P1_ERR] = p1_err;
    w_p01[`SPSF_B_P0_RXD] = p0_rxd;
    w_p01[`SPSF_B_P0_TXD] = p0_txd;
    w_mode = `SPSF_RST_WORD;
    w_mode[`SPSF_B_P0_MODE] = p0_mode;
    w_mode[`SPSF_B_P1_LINK] = p1_link;
    w_mode[`SPSF_B_P2_MODE] = p2_mode;
    w_mode[`SPSF_B_P1_AVAIL] = ~p1_busy;
    w_mode[`SPSF_B_P1_END] = p1_end;
    w_mode[`SPSF_B_P2_ERR] = p2_err;
    w_mode[`SPSF_B_P2_RXD] = p2_rxd;
    w_mode[`SPSF_B_P2_TXD] = p2_txd;
    w_mode[`SPSF_B_P2_AVAIL] = ~p2_busy;
    w_mode[`SPSF_B_P2_END] = p2_end;
  end

  // ----------------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------------
  // a bad link setting holds its interrupt bit set while it lasts, like the flag
  wire [`SPSF_EVENTS-1:0] irq_ev = {e_link_err | link_cfg_bad, e_p1_fail | e_p2_fail,
    p2_mode & e_p2_txd, p2_mode & e_p2_rx, e_p2_err, e_p1_err, p0_mode & e_p0_txd,
    p0_mode & e_p0_rx};

  wire bus_req = CYC_I & STB_I & ~ACK_O;
  wire bus_wr = bus_req & WE_I & SEL_I[0];

  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      irq_stat <= `SPSF_RST_IRQ;
      irq_en <= `SPSF_RST_IRQ;
      INT_O <= 1'b0;
    end else if (CE_I) begin
      if (bus_wr && ADR_I == `SPSF_OFS_IRQ_CLR) begin
        irq_stat <= irq_ev | (irq_stat & ~DAT_I[`SPSF_EVENTS-1:0]);
      end else begin
        irq_stat <= irq_ev | irq_stat;
      end
      if (bus_wr && ADR_I == `SPSF_OFS_IRQ_EN) begin
        irq_en <= DAT_I[`SPSF_EVENTS-1:0];
      end
      INT_O <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------------
  // wishbone read path
  // ----------------------------------------------------------------------
  reg [31:0] rd;

  always @* begin
    case (ADR_I)
      `SPSF_OFS_P01, `SPSF_OFS_P01_ALT: rd = {16'h0000, w_p01};
      `SPSF_OFS_MODE, `SPSF_OFS_MODE_ALT: rd = {16'h0000, w_mode};
      `SPSF_OFS_LINK, `SPSF_OFS_LINK_ALT: rd = {16'h0000, w_link};
      `SPSF_OFS_UNIT, `SPSF_OFS_UNIT_ALT: rd = {16'h0000, w_unit};
      `SPSF_OFS_IRQ_STAT: rd = {24'h00_0000, irq_stat};
      `SPSF_OFS_IRQ_EN: rd = {24'h00_0000, irq_en};
      `SPSF_OFS_ERR_P1: rd = {16'h0000, p1_errcode};
      `SPSF_OFS_ERR_P2: rd = {16'h0000, p2_errcode};
      default: rd = 32'h0000_0000;
    endcase
  end

  // status words are read-only: writes are acknowledged and dropped
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else if (CE_I) begin
      ACK_O <= bus_req;
      if (bus_req && !WE_I) begin
        DAT_O <= rd;
      end
    end
  end
endmodule

// ===== sim/spsf_assertions.sv
// spsf_assertions.sv: port-level checks for the serial status flag bank
// assumes: bound into spsf_top; CE_I high whenever a level is compared
`timescale 1ns/1ns
`include "spsf_map.vh"
module spsf_assertions (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire CE_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [31:0] DAT_O,
  input wire ACK_O,
  input wire P0_GP_MODE_I,
  input wire P2_GP_MODE_I,
  input wire P1_LINK_MODE_I,
  input wire P1_REM_BUSY_I,
  input wire P2_REM_BUSY_I,
  input wire [`SPSF_UNITS-1:0] UNIT_OK_I,
  input wire LINK_CFG_BAD_I
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  wire [`SPSF_UNITS+5:0] lv = {LINK_CFG_BAD_I, UNIT_OK_I, P2_REM_BUSY_I, P1_REM_BUSY_I,
    P1_LINK_MODE_I, P2_GP_MODE_I, P0_GP_MODE_I};
  reg [`SPSF_UNITS+5:0] lp;
  reg [2:0] qc;
  // levels pass a synchroniser, so only compare once they sat still for a while
  always @(posedge SYS_CLK_I) begin
    lp <= lv;
    if (RST_I || !CE_I || lv != lp)
      qc <= 3'h0;
    else if (qc != 3'h7)
      qc <= qc + 3'h1;
  end
  wire rd = ACK_O && !WE_I;
  wire ok = rd && qc == 3'h7 && lv == lp;
  wire md = ok && (ADR_I == `SPSF_OFS_MODE || ADR_I == `SPSF_OFS_MODE_ALT);
  wire un = ok && (ADR_I == `SPSF_OFS_UNIT || ADR_I == `SPSF_OFS_UNIT_ALT);
  wire lk = ok && (ADR_I == `SPSF_OFS_LINK || ADR_I == `SPSF_OFS_LINK_ALT);
  a_ack_next: assert property (CYC_I && STB_I && !ACK_O && CE_I |=> ACK_O)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ACK_O && CE_I |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (rd |-> DAT_O[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_mode_bits: assert property (md |-> DAT_O[2:0] == {P2_GP_MODE_I, P1_LINK_MODE_I, P0_GP_MODE_I})
    else $error("mode or link flag wrong");
  a_avail_bits: assert property (md |-> DAT_O[4] != P1_REM_BUSY_I && DAT_O[10] != P2_REM_BUSY_I)
    else $error("availability flag wrong");
  a_unit_bits: assert property (un |-> DAT_O[15:0] == {12'h000, UNIT_OK_I})
    else $error("unit assurance bits wrong");
  a_link_cfg: assert property (lk && LINK_CFG_BAD_I |-> DAT_O[0])
    else $error("link error not set by bad settings");
  a_clr_zero: assert property (rd && ADR_I == `SPSF_OFS_IRQ_CLR |-> DAT_O == 32'h0000_0000)
    else $error("clear register reads nonzero");
  c_mode_read: cover property (md);
  c_cfg_link: cover property (lk && LINK_CFG_BAD_I);
  c_ack_write: cover property (ACK_O && WE_I);
endmodule
bind spsf_top spsf_assertions spsf_assertions_i (.SYS_CLK_I, .RST_I, .CE_I, .CYC_I, .STB_I,
  .WE_I, .ADR_I, .DAT_O, .ACK_O, .P0_GP_MODE_I, .P2_GP_MODE_I, .P1_LINK_MODE_I,
  .P1_REM_BUSY_I, .P2_REM_BUSY_I, .UNIT_OK_I, .LINK_CFG_BAD_I);

// ===== sim/tb_spsf_top.sv
// tb_spsf_top.sv: self-checking bench for the serial status flag bank
// assumes: one-cycle wishbone ack; flags settle within six edges of a pin rise
`timescale 1ns/1ns
`include "spsf_map.vh"
module tb_spsf_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0000_0000;
  reg [13:0] ev = 14'h0000;
  // {cfg bad, units, p2 busy, p1 busy, p1 link, p2 mode, p0 mode}
  reg [9:0] lv = 10'h000;
  reg [15:0] c1 = 16'h0000;
  reg [15:0] c2 = 16'h0000;
  reg [15:0] m1;
  reg [15:0] m2;
  reg [31:0] seed = 32'h0000_0052;
  reg [31:0] r;
  reg [31:0] d;
  reg [31:0] rdat;
  wire [31:0] dat;
  wire ack;
  wire irq_o;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer fl, irq, en, i, n;
  spsf_top spsf_top_i (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(cyc),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(dat), .ACK_O(ack),
    .INT_O(irq_o), .P0_GP_MODE_I(lv[0]), .P2_GP_MODE_I(lv[1]), .P1_LINK_MODE_I(lv[2]),
    .P1_REM_BUSY_I(lv[3]), .P2_REM_BUSY_I(lv[4]), .UNIT_OK_I(lv[8:5]), .LINK_CFG_BAD_I(lv[9]),
    .P0_RX_END_I(ev[0]), .P0_TX_DONE_I(ev[1]), .P0_TX_REQ_I(ev[2]), .P1_TX_ERR_I(ev[3]),
    .P1_TX_REQ_I(ev[4]), .P2_RX_END_I(ev[5]), .P2_TX_DONE_I(ev[6]), .P2_TX_REQ_I(ev[7]),
    .P2_TX_ERR_I(ev[8]), .LINK_TX_ERR_I(ev[9]), .P1_REM_DONE_I(ev[10]),
    .P1_REM_FAIL_I(ev[11]), .P1_REM_CODE_I(c1), .P2_REM_DONE_I(ev[12]),
    .P2_REM_FAIL_I(ev[13]), .P2_REM_CODE_I(c2));
  always #2 clk = ~clk;
  function [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  // the status words repeat 16 bytes higher, so the mirror folds onto one table
  function [31:0] exp_word(input [7:0] a);
    case (a < 8'h20 ? {4'h0, a[3:0]} : a)
      8'h00: exp_word = {fl[1:0], 6'h00, fl[2], 7'h00};
      8'h04: exp_word = {fl[7], !lv[4], fl[5:3], 1'b0, fl[6], !lv[3], 1'b0, lv[1], lv[2], lv[0]};
      8'h08: exp_word = fl[8];
      8'h0C: exp_word = lv[8:5];
      8'h20: exp_word = irq;
      8'h24: exp_word = en;
      8'h2C: exp_word = m1;
      8'h30: exp_word = m2;
      default: exp_word = 0;
    endcase
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task bus(input w, input [7:0] a, input [31:0] dw);
    @(posedge clk);
    {cyc, we, adr, wdat} <= {1'b1, w, a, dw};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat;
    cyc <= 1'b0;
  endtask
  task rd_chk(input [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp_word(a));
  endtask
  // pins are synchronised, so pulses stay high three edges and low six
  task fire(input integer k);
    @(posedge clk);
    ev[k] <= 1'b1;
    repeat (3) @(posedge clk);
    ev[k] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_fail = n_fail + 1;
    complete_run;
  end
  initial begin
    {fl, irq, en, m1, m2} = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 64; i = i + 4)
      rd_chk(i[7:0]);
    $display("reset test done");
    for (i = 0; i < 400; i = i + 1) begin
      r = xs();
      c1 <= r[15:0];
      c2 <= r[31:16];
      repeat (4) @(posedge clk);
      n = r[8:4] % 14;
      d = (r >> 16) & (lv[9] ? 32'h0000_007F : 32'h0000_00FF);
      case (r[3:0])
        4'h0: begin
          lv <= r[25:16];
          repeat (10) @(posedge clk);
          if (lv[9])
            {fl[8], irq[7]} = 2'b11;
        end
        4'h1: begin
          bus(1'b1, `SPSF_OFS_IRQ_EN, d);
          en = d;
        end
        4'h2: begin
          bus(1'b1, `SPSF_OFS_IRQ_CLR, d);
          irq = irq & ~d;
        end
        4'h3: bus(1'b1, {3'h0, r[30:28], 2'h0}, r);
        // a pulse that comes and goes while frozen is never seen: flags stay as they were
        4'h4: begin
          ce <= 1'b0;
          fire(n);
          ce <= 1'b1;
        end
        default: if ((n != 2 || lv[0]) && (n != 7 || lv[1])) begin
          fire(n);
          case (n)
            0, 1: if (lv[0]) {fl[n], irq[n]} = 2'b11;
            2: fl[1] = 0;
            3: {fl[2], irq[2]} = 2'b11;
            4: fl[2] = 0;
            5, 6: if (lv[1]) {fl[n-1], irq[n-1]} = 2'b11;
            7: {fl[5], fl[3]} = 2'b00;
            8: {fl[3], irq[3]} = 2'b11;
            9: {fl[8], irq[7]} = 2'b11;
            10: fl[6] = 0;
            11: {fl[6], irq[6], m1} = {2'b11, c1};
            12: fl[7] = 0;
            default: {fl[7], irq[6], m2} = {2'b11, c2};
          endcase
        end
      endcase
      rd_chk({2'h0, r[31:28], 2'h0});
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, irq_o}, {31'h0000_0000, (irq & en) != 0});
    end
    $display("random test done");
    complete_run;
  end
endmodule
